/* File: inc/trig_pkg.sv */
// Shared constants, enumerations and carriers of the trigger model block.
// Assumes one 50 MHz clock and a host that issues one-cycle command strobes.
// Contract
// - Range and autorange kept per function.
// - Pick lowest range covering requested maximum.
// - Round requested range value to integer first.
// - Range query returns present full-scale value.
// - Trigger setting writes never arm the model.
// - Idle state, two arm layers, trigger layer.
// - External source: one reading per pulse.
// - Infinite count never leaves trigger layer.
// - Abort returns to idle until next sequence_b.
// - External second arm layer waits for pulse.
// - Source_a source reads back to back.
// - Timer source: first reading now, then periodic.
// - Instrument reset: source_a source, idle state.
// - Instrument reset spares status; preset restores enables.
// - Enabled status transition asserts service request.
// - Mask 512 passes only buffer full.
// - Serial poll releases service request.
// - No second request until event register cleared.
// - Buffer full sets measurement event bit 9.
// - Next mode stores at once, stops when full.
package trig_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 20; // Clock period in ns.
	localparam int MS_NS = 1000000; // One millisecond in ns.
	localparam int MS_CYCLES = (MS_NS + CLK_NS - 1) / CLK_NS; // Cycles per ms.
	// ----------------------------------------------------------------
	// Ranges
	// ----------------------------------------------------------------
	localparam int NFUNC = 4; // Measurement functions.
	localparam int NRANGE = 4; // Ranges per function.
	localparam int RIDX_W = 2; // Range index width.
	localparam int FRAC_W = 8; // Fraction bits of a range request.
	localparam logic [NRANGE-1:0][31:0] RANGE_FS = {32'h3E8, 32'hC8, 32'h14, 32'h2};
	// ----------------------------------------------------------------
	// Status
	// ----------------------------------------------------------------
	localparam int EVT_BFL_BIT = 9; // Buffer full event bit.
	localparam int EVT_IDLE_BIT = 10; // Idle condition bit.
	localparam int STB_MSS_BIT = 0; // Measurement summary bit.
	localparam int STB_RQS_BIT = 6; // Request service bit.
	localparam logic [15:0] BFL_MASK = 16'h0200; // Value 512.
	localparam logic [15:0] EN_PRESET = 16'h0000; // Enable after preset.
	localparam logic [15:0] PTR_PRESET = 16'hFFFF; // Rising filter preset.
	localparam logic [15:0] NTR_PRESET = 16'h0000; // Falling filter preset.
	localparam logic [15:0] CPREV_RST = 16'h0400; // Idle condition at reset.
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {IDLE, ARM1, ARM2, TRIG} layer_t;
	typedef enum logic [1:0] {SRC_A, SRC_EXT, SRC_TIMER} trig_src_t;
	typedef enum logic {ARM_SRC_A, ARM_SRC_EXT} arm_src_t;
	typedef struct packed {
		trig_src_t trig_src; // Trigger layer source.
		arm_src_t arm_src; // Second arm layer source.
		logic trig_inf; // Infinite trigger count.
		logic [15:0] trig_count; // Readings per pass.
		logic [15:0] arm_count; // Passes of the second arm layer.
		logic [15:0] timer_ms; // Timer interval in ms.
	} trig_cfg_t;
	localparam trig_cfg_t CFG_RST = '{SRC_A, ARM_SRC_A, 1'b0, 16'h0001, 16'h0001, 16'h0032};
endpackage

/* File: design/trig_sync.sv */
// Two-stage synchroniser and edge detector for the external trigger pin.
// Assumes the pin pulse is high for at least two clock periods.
`timescale 1ns/10ps
`default_nettype none
module trig_sync (
	input wire logic ref_clk_i, // Clock.
	input wire logic rst_n_i, // Asynchronous reset, active low.
	input wire logic ext_trig_i, // Raw external trigger pin.
	output logic pulse_o // One-cycle pulse per rising edge.
);
	import trig_pkg::*;
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] sh; // Stage 0 and 1 synchronise, stage 2 delays.
		logic pulse; // Registered edge pulse.
	} sync_state_t;
	sync_state_t s; // Present state.
	sync_state_t n; // Next state.
	// Only stage 1 and 2 feed the edge detector.
	always_comb
	begin
		n = s;
		n.sh = {s.sh[1:0], ext_trig_i};
		n.pulse = s.sh[1] & ~s.sh[2];
	end
	// State register.
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			s <= '0;
		else
			s <= n;
	end
	assign pulse_o = s.pulse;
	// Each edge yields exactly one pulse cycle.
	chk_sync_one_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		pulse_o |=> !pulse_o) else $error("trigger pulse longer than one cycle");
endmodule
`default_nettype wire

/* File: design/range_select.sv */
// Per-function range and autorange store with full-scale readback.
// Assumes requests carry FRAC_W fraction bits and magnitudes are integers.
`timescale 1ns/10ps
`default_nettype none
module range_select (
	input wire logic ref_clk_i, // Clock.
	input wire logic rst_n_i, // Asynchronous reset, active low.
	input wire logic [1:0] func_sel_i, // Active function.
	input wire logic rng_wr_i, // Range write strobe.
	input wire logic [31:0] rng_val_i, // Requested maximum, fixed point.
	input wire logic auto_wr_i, // Autorange write strobe.
	input wire logic auto_on_i, // Autorange value.
	input wire logic rdg_done_i, // Reading finished.
	input wire logic [31:0] rdg_mag_i, // Reading magnitude, integer.
	output logic [31:0] rng_fs_o, // Full scale of present range.
	output logic auto_o // Autorange of active function.
);
	import trig_pkg::*;
	typedef struct packed {
		logic [NFUNC-1:0][RIDX_W-1:0] idx; // Range per function.
		logic [NFUNC-1:0] auto_on; // Autorange per function.
		logic [31:0] fs; // Full-scale readback.
		logic auto_q; // Autorange readback.
	} rng_state_t;
	rng_state_t s; // Present state.
	rng_state_t n; // Next state.
	// Round half up to an integer.
	function automatic logic [31:0] round_q(input logic [31:0] v);
		round_q = (v >> FRAC_W) + {31'h0, v[FRAC_W-1]};
	endfunction
	// Lowest range whose full scale covers the value, else the top one.
	function automatic logic [RIDX_W-1:0] pick_range(input logic [31:0] v);
		pick_range = RIDX_W'(NRANGE - 1);
		for (int i = NRANGE - 1; i >= 0; i--)
			if (RANGE_FS[i] >= v)
				pick_range = RIDX_W'(i);
	endfunction
	// Only the active function's entry is touched.
	always_comb
	begin
		n = s;
		if (s.auto_on[func_sel_i] && rdg_done_i)
			n.idx[func_sel_i] = pick_range(rdg_mag_i);
		if (auto_wr_i)
			n.auto_on[func_sel_i] = auto_on_i;
		if (rng_wr_i)
		begin
			n.idx[func_sel_i] = pick_range(round_q(rng_val_i));
			n.auto_on[func_sel_i] = 1'b0;
		end
		n.fs = RANGE_FS[n.idx[func_sel_i]];
		n.auto_q = n.auto_on[func_sel_i];
	end
	// State register.
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			s <= '0;
		else
			s <= n;
	end
	assign rng_fs_o = s.fs;
	assign auto_o = s.auto_q;
	chk_rng_readback: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		rng_wr_i |=> rng_fs_o == RANGE_FS[pick_range(round_q($past(rng_val_i)))])
		else $error("range readback not full scale of chosen range");
	chk_func_indep: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(auto_wr_i && !rng_wr_i) |=> ($past(func_sel_i) == 2'h0 || s.auto_on[0] == $past(s.auto_on[0])))
		else $error("autorange write touched another function");
endmodule
`default_nettype wire

/* File: design/trig_model.sv */
// Layered arm and trigger sequencer with reading buffer fill and service request.
// Assumes commands are one-cycle strobes from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module trig_model #(
	parameter int MS_CYC = trig_pkg::MS_CYCLES // Cycles per timer millisecond.
) (
	input wire logic ref_clk_i, // Clock, 50 MHz.
	input wire logic rst_n_i, // Asynchronous reset, active low.
	input wire logic inst_rst_i, // Instrument reset strobe.
	input wire logic sequence_b_i, // Sequence_b strobe.
	input wire logic abort_i, // Abort strobe.
	input wire logic cfg_wr_i, // Trigger settings write strobe.
	input wire trig_pkg::trig_cfg_t cfg_i, // Trigger settings.
	input wire logic ext_trig_i, // External trigger pin.
	output logic meas_start_o, // Start one reading, pulse.
	input wire logic meas_done_i, // Reading finished, pulse.
	input wire logic [31:0] rdg_mag_i, // Reading magnitude.
	input wire logic [1:0] func_sel_i, // Active function.
	input wire logic rng_wr_i, // Range write strobe.
	input wire logic [31:0] rng_val_i, // Requested range.
	input wire logic auto_wr_i, // Autorange write strobe.
	input wire logic auto_on_i, // Autorange value.
	output logic [31:0] rng_fs_o, // Present full scale.
	output logic auto_o, // Autorange state.
	output trig_pkg::layer_t layer_o, // Present layer.
	input wire logic buf_arm_i, // Arm buffer in next mode.
	input wire logic [15:0] buf_points_i, // Buffer size.
	output logic [15:0] buf_count_o, // Stored readings.
	input wire logic [15:0] cond_i, // Other condition bits.
	input wire logic stat_preset_i, // Status preset strobe.
	input wire logic cls_i, // Clear status strobe.
	input wire logic en_wr_i, // Event enable write strobe.
	input wire logic [15:0] en_i, // Event enable mask.
	input wire logic trans_wr_i, // Transition filter write strobe.
	input wire logic [15:0] ptr_i, // Rising transition filter.
	input wire logic [15:0] ntr_i, // Falling transition filter.
	input wire logic sre_wr_i, // Request enable write strobe.
	input wire logic [7:0] sre_i, // Request enable mask.
	input wire logic evt_rd_i, // Event register read strobe.
	output logic [15:0] evt_o, // Event value of last read.
	input wire logic spoll_i, // Serial poll strobe.
	output logic [7:0] stb_o, // Status byte.
	output logic srq_o, // Request line level when driven.
	output logic srq_oe_o // Request line pulled low.
);
	import trig_pkg::*;
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		layer_t st; // Layer of the model.
		trig_cfg_t cfg; // Latched trigger settings.
		logic [15:0] tcnt; // Readings in this pass.
		logic [15:0] acnt; // Passes of second arm layer.
		logic busy; // Reading in flight.
		logic pend; // Trigger waiting for a reading slot.
		logic start; // Start pulse.
		logic [31:0] pre; // Millisecond prescaler.
		logic [15:0] ms; // Milliseconds into interval.
		logic bstore; // Buffer is storing.
		logic bfull; // Buffer full condition.
		logic [15:0] bcnt; // Stored readings.
		logic [15:0] evt; // Measurement event register.
		logic [15:0] evt_out; // Value returned by last read.
		logic [15:0] en; // Event enable mask.
		logic [15:0] ptr; // Rising filter.
		logic [15:0] ntr; // Falling filter.
		logic [15:0] cprev; // Conditions of last cycle.
		logic [7:0] sre; // Request enable.
		logic req_prev; // Summary request of last cycle.
		logic srq; // Service request pending.
		logic [7:0] stb; // Status byte.
	} tm_state_t;
	localparam tm_state_t ST_RST = '{st: IDLE, cfg: CFG_RST, ptr: PTR_PRESET,
		ntr: NTR_PRESET, en: EN_PRESET, cprev: CPREV_RST, default: '0};
	tm_state_t s; // Present state.
	tm_state_t n; // Next state.
	logic ext_pulse; // Synchronised external edge.
	logic tick; // Timer interval elapsed.
	logic last_rdg; // This reading ends the pass.
	logic [15:0] cond; // Full condition vector.
	logic [15:0] rise; // Filtered rising transitions.
	logic [15:0] fall; // Filtered falling transitions.
	logic mss; // Measurement summary.
	logic [7:0] sum; // Summary bits of the status byte.
	logic req; // Enabled summary present.
	logic req_rise; // New request this cycle.
	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	// Pin synchroniser.
	trig_sync u_sync (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.ext_trig_i(ext_trig_i),
		.pulse_o(ext_pulse)
	);
	// Range store, fed by finished readings.
	range_select u_rng (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.func_sel_i(func_sel_i),
		.rng_wr_i(rng_wr_i),
		.rng_val_i(rng_val_i),
		.auto_wr_i(auto_wr_i),
		.auto_on_i(auto_on_i),
		.rdg_done_i(meas_done_i),
		.rdg_mag_i(rdg_mag_i),
		.rng_fs_o(rng_fs_o),
		.auto_o(auto_o)
	);
	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Timer, layers, buffer and status all in one pass.
	always_comb
	begin
		n = s;
		n.start = 1'b0;
		tick = 1'b0;
		last_rdg = !s.cfg.trig_inf && (s.tcnt + 16'h0001 >= s.cfg.trig_count);
		// Timer runs only while the timer source owns the trigger layer.
		if (s.st == TRIG && s.cfg.trig_src == SRC_TIMER)
		begin
			if (s.pre >= 32'(MS_CYC - 1))
			begin
				n.pre = '0;
				if (s.ms + 16'h0001 >= s.cfg.timer_ms)
				begin
					n.ms = '0;
					tick = 1'b1;
				end
				else
					n.ms = s.ms + 16'h0001;
			end
			else
				n.pre = s.pre + 32'h1;
		end
		else
		begin
			n.pre = '0;
			n.ms = '0;
		end
		// Layer sequencing.
		case (s.st)
			IDLE:
			begin
				// Triggers are ignored here; only sequence_b leaves.
				if (sequence_b_i)
				begin
					n.st = ARM1;
					n.acnt = '0;
				end
			end
			ARM1:
			begin
				// First arm layer passes at once.
				n.st = ARM2;
			end
			ARM2:
			begin
				// External source holds here until a pin edge.
				if (s.cfg.arm_src == ARM_SRC_A || ext_pulse)
				begin
					n.st = TRIG;
					n.tcnt = '0;
					n.pend = (s.cfg.trig_src != SRC_EXT);
				end
			end
			TRIG:
			begin
				if (ext_pulse && s.cfg.trig_src == SRC_EXT)
					n.pend = 1'b1;
				if (tick)
					n.pend = 1'b1;
				if (meas_done_i && s.busy)
				begin
					n.busy = 1'b0;
					if (s.cfg.trig_src == SRC_A)
						n.pend = 1'b1;
					if (s.bstore)
					begin
						n.bcnt = s.bcnt + 16'h0001;
						if (s.bcnt + 16'h0001 >= buf_points_i)
						begin
							n.bstore = 1'b0;
							n.bfull = 1'b1;
						end
					end
					// Infinite count keeps the model here.
					if (last_rdg)
					begin
						n.pend = 1'b0;
						n.tcnt = '0;
						if (s.acnt + 16'h0001 >= s.cfg.arm_count)
							n.st = IDLE;
						else
						begin
							n.acnt = s.acnt + 16'h0001;
							n.st = ARM2;
						end
					end
					else
						n.tcnt = s.tcnt + 16'h0001;
				end
				else if (s.pend && !s.busy)
				begin
					n.start = 1'b1;
					n.busy = 1'b1;
					n.pend = 1'b0;
				end
			end
			default:
			begin
				n.st = IDLE;
			end
		endcase
		// Settings are latched only; the layer is left alone.
		if (cfg_wr_i)
			n.cfg = cfg_i;
		if (abort_i || inst_rst_i)
		begin
			n.st = IDLE;
			n.busy = 1'b0;
			n.pend = 1'b0;
			n.start = 1'b0;
		end
		if (inst_rst_i)
			n.cfg = CFG_RST;
		// Next-mode fill starts from empty.
		if (buf_arm_i)
		begin
			n.bstore = 1'b1;
			n.bcnt = '0;
			n.bfull = 1'b0;
		end
		// Status: conditions and transition filters.
		cond = cond_i;
		cond[EVT_BFL_BIT] = s.bfull;
		cond[EVT_IDLE_BIT] = (s.st == IDLE);
		rise = cond & ~s.cprev & s.ptr;
		fall = ~cond & s.cprev & s.ntr;
		n.cprev = cond;
		if (evt_rd_i)
			n.evt_out = s.evt;
		if (evt_rd_i || cls_i)
			n.evt = '0;
		n.evt = n.evt | rise | fall;
		// Enables change only by write or preset, never instrument reset.
		if (en_wr_i)
			n.en = en_i;
		if (trans_wr_i)
		begin
			n.ptr = ptr_i;
			n.ntr = ntr_i;
		end
		if (stat_preset_i)
		begin
			n.en = EN_PRESET;
			n.ptr = PTR_PRESET;
			n.ntr = NTR_PRESET;
		end
		if (sre_wr_i)
			n.sre = sre_i;
		mss = |(s.evt & s.en);
		sum = 8'h00;
		sum[STB_MSS_BIT] = mss;
		req = |(sum & s.sre);
		// A held summary cannot raise a second request.
		req_rise = req & ~s.req_prev;
		n.req_prev = req;
		if (spoll_i)
			n.srq = 1'b0;
		if (req_rise)
			n.srq = 1'b1;
		n.stb = sum;
		n.stb[STB_RQS_BIT] = n.srq;
	end
	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Single register for the whole state.
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			s <= ST_RST;
		else
			s <= n;
	end
	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign meas_start_o = s.start;
	assign layer_o = s.st;
	assign buf_count_o = s.bcnt;
	assign evt_o = s.evt_out;
	assign stb_o = s.stb;
	// Open-drain request: only ever pulled low.
	assign srq_o = 1'b0;
	assign srq_oe_o = s.srq;
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// No command in flight that could move the layer.
	sequence s_quiet;
		!abort_i && !inst_rst_i;
	endsequence
	// A reading completes in the source_a source with more to go.
	sequence s_imm_done;
		s.st == TRIG && s.cfg.trig_src == SRC_A && meas_done_i && s.busy && !last_rdg;
	endsequence
	// The next start shows two cycles after the done, so one after the quiet cycle.
	sequence s_restart;
		##1 meas_start_o;
	endsequence
	chk_abort_idle: assert property (abort_i |=> layer_o == IDLE)
		else $error("abort did not return to idle");
	chk_rst_idle: assert property (inst_rst_i |=>
		layer_o == IDLE && s.cfg.trig_src == SRC_A)
		else $error("instrument reset left source or layer");
	chk_cfg_noarm: assert property ((s.st == IDLE && cfg_wr_i && !sequence_b_i)
		|=> layer_o == IDLE) else $error("settings write armed the model");
	chk_idle_ignores: assert property ((s.st == IDLE) |=> !meas_start_o)
		else $error("reading started from idle");
	chk_ext_one: assert property ((s.st == TRIG && s.cfg.trig_src == SRC_EXT
		&& !s.busy && !s.pend && ext_pulse && !cfg_wr_i) ##0 s_quiet ##1 s_quiet
		|=> meas_start_o) else $error("external pulse gave no reading");
	chk_inf_stay: assert property ((s.st == TRIG && s.cfg.trig_inf && !cfg_wr_i)
		##0 s_quiet |=> layer_o == TRIG) else $error("infinite count left trigger layer");
	chk_arm2_hold: assert property ((s.st == ARM2 && s.cfg.arm_src == ARM_SRC_EXT
		&& !ext_pulse) ##0 s_quiet |=> layer_o == ARM2)
		else $error("second arm layer passed without pulse");
	chk_imm_next: assert property ((s_imm_done ##0 !cfg_wr_i) ##0 s_quiet
		##1 s_quiet |-> ##0 s_restart) else $error("source_a source did not restart");
	chk_timer_first: assert property ((s.st == ARM2 && n.st == TRIG
		&& s.cfg.trig_src == SRC_TIMER && !cfg_wr_i) ##1 s_quiet |=> meas_start_o)
		else $error("timer source missed first reading");
	chk_rst_status: assert property (inst_rst_i && !en_wr_i && !stat_preset_i
		|=> $stable(s.en)) else $error("instrument reset touched enables");
	chk_srq_set: assert property (req_rise |=> srq_oe_o ##0 stb_o[STB_RQS_BIT])
		else $error("request not raised on enabled event");
	chk_bfl_mask: assert property ((s.en == BFL_MASK)
		|=> stb_o[STB_MSS_BIT] == $past(s.evt[EVT_BFL_BIT]))
		else $error("mask 512 summary mismatch");
	chk_spoll_rel: assert property ((spoll_i && !req_rise) |=> !srq_oe_o)
		else $error("serial poll did not release request");
	chk_evt_sticky: assert property ((!evt_rd_i && !cls_i)
		|=> (s.evt & $past(s.evt)) == $past(s.evt)) else $error("event bit lost uncleared");
	chk_bfl_event: assert property ((s.bfull && !s.cprev[EVT_BFL_BIT]
		&& s.ptr[EVT_BFL_BIT]) |=> s.evt[EVT_BFL_BIT])
		else $error("buffer full did not set event bit");
	chk_buf_stop: assert property ((!s.bstore && !buf_arm_i) |=> $stable(buf_count_o))
		else $error("buffer stored while stopped");
	chk_rqs_bit: assert property (stb_o[STB_RQS_BIT] == srq_oe_o)
		else $error("status byte bit 6 disagrees with request");
endmodule
`default_nettype wire

/* File: testbench/meas_partner.sv */
// Measurement engine stand-in: answers each start with one done pulse.
// Assumes start pulses are one cycle wide on the shared clock.
`timescale 1ns/10ps
`default_nettype none
module meas_partner #(
	parameter int LAT = 3 // Done comes LAT + 1 cycles after start.
) (
	input wire logic ref_clk_i, // Clock.
	input wire logic rst_n_i, // Reset, active low.
	input wire logic start_i, // Start of a reading.
	output logic done_o, // Reading finished, pulse.
	output logic [15:0] starts_o // Starts seen so far.
);
	logic [7:0] cnt_q; // Cycles left of the reading.
	// A new start restarts the count; done pulses as it runs out.
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_q <= 8'h00;
			done_o <= 1'b0;
			starts_o <= 16'h0000;
		end
		else
		begin
			done_o <= (cnt_q == 8'h01);
			cnt_q <= start_i ? 8'(LAT) : cnt_q - ((cnt_q != 8'h00) ? 8'h01 : 8'h00);
			starts_o <= starts_o + (start_i ? 16'h0001 : 16'h0000);
		end
	end
endmodule
`default_nettype wire

/* File: testbench/trig_model_bench.sv */
// Self-checking bench of the trigger sequencer, range store and request logic.
// Assumes the measurement partner beside it and a shortened timer tick.
`timescale 1ns/10ps
`default_nettype none
`define check(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; \
	$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module trig_model_bench;
	import trig_pkg::*;
	localparam int IRST = 0, INIT = 1, ABRT = 2, CFGW = 3, BARM = 4, PRST = 5, CLS = 6;
	localparam int ENW = 7, SREW = 8, EVRD = 9, POLL = 10, RNGW = 11, AUTW = 12;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [12:0] stv = '0; // Command strobes, one bit each.
	logic ext_trig_i = 1'b0;
	logic [1:0] func_sel_i = 2'h0;
	logic [31:0] rng_val_i = 32'h0;
	logic [31:0] rdg_mag_i = 32'h5; // Magnitude reported with each reading.
	logic auto_on_i = 1'b0;
	logic [15:0] buf_points_i = 16'h2;
	logic [15:0] en_i = 16'h0;
	logic [7:0] sre_i = 8'h0;
	trig_cfg_t cfg_i = CFG_RST;
	logic meas_start_o, meas_done_i, auto_o, srq_oe_o, srq_o;
	logic [31:0] rng_fs_o;
	layer_t layer_o;
	logic [15:0] buf_count_o, evt_o, starts, s0;
	logic [7:0] stb_o;
	int fails = 0, n_compared = 0, n;
	trig_model #(.MS_CYC(4)) u_trig_model (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .inst_rst_i(stv[IRST]),
		.sequence_b_i(stv[INIT]), .abort_i(stv[ABRT]), .cfg_wr_i(stv[CFGW]), .cfg_i(cfg_i),
		.ext_trig_i(ext_trig_i), .meas_start_o(meas_start_o), .meas_done_i(meas_done_i),
		.rdg_mag_i(rdg_mag_i), .func_sel_i(func_sel_i), .rng_wr_i(stv[RNGW]),
		.rng_val_i(rng_val_i), .auto_wr_i(stv[AUTW]), .auto_on_i(auto_on_i),
		.rng_fs_o(rng_fs_o), .auto_o(auto_o), .layer_o(layer_o), .buf_arm_i(stv[BARM]),
		.buf_points_i(buf_points_i), .buf_count_o(buf_count_o), .cond_i(16'h0),
		.stat_preset_i(stv[PRST]), .cls_i(stv[CLS]), .en_wr_i(stv[ENW]), .en_i(en_i),
		.trans_wr_i(1'b0), .ptr_i(16'hFFFF), .ntr_i(16'h0), .sre_wr_i(stv[SREW]),
		.sre_i(sre_i), .evt_rd_i(stv[EVRD]), .evt_o(evt_o), .spoll_i(stv[POLL]),
		.stb_o(stb_o), .srq_o(srq_o), .srq_oe_o(srq_oe_o));
	meas_partner u_meas_partner (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.start_i(meas_start_o), .done_o(meas_done_i), .starts_o(starts));
	// Free-running 50 MHz clock and an 8-cycle reset.
	initial forever #10 ref_clk_i = ~ref_clk_i;
	initial
	begin
		repeat (8) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
	end
	// Prints the counts and the verdict, then stops the run.
	task automatic finish_test;
		$display("compared %0d mismatched %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// One-cycle strobe; returns once its effect is visible.
	task automatic strobe(input int b);
		@(negedge ref_clk_i);
		stv[b] = 1'b1;
		@(negedge ref_clk_i);
		stv = '0;
		@(negedge ref_clk_i);
	endtask
	// Pin pulse held well past the synchroniser's minimum.
	task automatic ext_pulse;
		ext_trig_i = 1'b1;
		repeat (3) @(negedge ref_clk_i);
		ext_trig_i = 1'b0;
		repeat (12) @(negedge ref_clk_i);
	endtask
	// Bounded wait for a layer; running out ends the run.
	task automatic wait_layer(input layer_t l);
		for (n = 0; layer_o !== l; n++)
		begin
			if (n == 60)
			begin
				`check(layer_o, l)
				finish_test();
			end
			@(negedge ref_clk_i);
		end
	endtask
	// Ranges follow rounding and stay with their own function.
	task automatic test_range;
		logic [31:0] req[3] = '{32'h266, 32'h1473, 32'hC880};
		logic [31:0] fs[3] = '{32'h2, 32'h14, 32'h3E8};
		`check(rng_fs_o, 32'h2)
		`check(layer_o, IDLE)
		for (int i = 0; i < 3; i++)
		begin
			rng_val_i = req[i];
			strobe(RNGW);
			`check(rng_fs_o, fs[i])
		end
		func_sel_i = 2'h1;
		auto_on_i = 1'b1;
		strobe(AUTW);
		`check(auto_o, 1'b1)
		func_sel_i = 2'h0;
		repeat (2) @(negedge ref_clk_i);
		`check(auto_o, 1'b0)
		`check(rng_fs_o, 32'h3E8)
		$display("test_range done");
	endtask
	// External one-shot triggering, infinite count, then abort.
	task automatic test_ext;
		cfg_i = '{SRC_EXT, ARM_SRC_A, 1'b1, 16'h1, 16'h1, 16'h32};
		strobe(CFGW);
		`check(layer_o, IDLE)
		strobe(INIT);
		wait_layer(TRIG);
		s0 = starts;
		ext_pulse();
		ext_pulse();
		`check(starts - s0, 16'h2)
		`check(layer_o, TRIG)
		strobe(ABRT);
		`check(layer_o, IDLE)
		ext_pulse();
		`check(starts - s0, 16'h2)
		$display("test_ext done");
	endtask
	// Second arm layer on the pin, back-to-back readings, instrument reset.
	task automatic test_arm2;
		cfg_i = '{SRC_A, ARM_SRC_EXT, 1'b1, 16'h1, 16'h1, 16'h32};
		strobe(CFGW);
		strobe(INIT);
		repeat (10) @(negedge ref_clk_i);
		`check(layer_o, ARM2)
		ext_pulse();
		`check(layer_o, TRIG)
		s0 = starts;
		repeat (48) @(negedge ref_clk_i);
		`check(starts - s0, 16'h8)
		strobe(IRST);
		`check(layer_o, IDLE)
		strobe(INIT);
		s0 = starts;
		repeat (24) @(negedge ref_clk_i);
		`check(starts != s0, 1'b1)
		strobe(ABRT);
		$display("test_arm2 done");
	endtask
	// Timer source: a reading at once, then one per interval; autorange follows readings.
	task automatic test_timer;
		cfg_i = '{SRC_TIMER, ARM_SRC_A, 1'b1, 16'h1, 16'h1, 16'h2};
		strobe(CFGW);
		func_sel_i = 2'h1;
		rdg_mag_i = 32'h64;
		s0 = starts;
		strobe(INIT);
		repeat (4) @(negedge ref_clk_i);
		`check(starts - s0, 16'h1)
		repeat (40) @(negedge ref_clk_i);
		`check(starts - s0, 16'h6)
		`check(rng_fs_o, 32'hC8)
		func_sel_i = 2'h0;
		repeat (2) @(negedge ref_clk_i);
		`check(rng_fs_o, 32'h3E8)
		strobe(ABRT);
		$display("test_timer done");
	endtask
	// One counted pass filling a two-place buffer from three readings.
	task automatic fill_pass;
		s0 = starts;
		strobe(BARM);
		strobe(INIT);
		wait_layer(IDLE);
		`check(starts - s0, 16'h3)
		`check(buf_count_o, 16'h2)
		repeat (6) @(negedge ref_clk_i);
	endtask
	// Buffer-full request, poll release and one request per event.
	task automatic test_srq;
		strobe(PRST);
		strobe(CLS);
		en_i = BFL_MASK;
		strobe(ENW);
		sre_i = 8'h01;
		strobe(SREW);
		strobe(IRST);
		cfg_i = '{SRC_A, ARM_SRC_A, 1'b0, 16'h3, 16'h1, 16'h32};
		strobe(CFGW);
		fill_pass();
		`check(srq_oe_o, 1'b1)
		`check(srq_o, 1'b0)
		`check(stb_o[STB_MSS_BIT], 1'b1)
		`check(stb_o[STB_RQS_BIT], 1'b1)
		strobe(POLL);
		`check(srq_oe_o, 1'b0)
		fill_pass();
		`check(srq_oe_o, 1'b0)
		strobe(EVRD);
		`check(evt_o[EVT_BFL_BIT], 1'b1)
		fill_pass();
		`check(srq_oe_o, 1'b1)
		$display("test_srq done");
	endtask
	// Main sequence.
	initial
	begin
		repeat (9) @(negedge ref_clk_i);
		test_range();
		test_ext();
		test_arm2();
		test_timer();
		test_srq();
		finish_test();
	end
endmodule
`default_nettype wire
